// ---- rtl/jk_bistable_with_polarity.sv ----
`timescale 1ns/1ps
`include "jk_bistable_defs.svh"

// Operation
// - Unmarked terminal: one is HIGH; marked terminal: one is LOW.
// - Only an input's active level or edge may change the outputs.
// - Two complementary outputs; true output is the state, other its inverse; here both forcing inputs active drive both outputs to logic one.
// - Preparatory inputs only select the next state, never change outputs directly.
// - Active command edge loads the state chosen by sampled preparatory inputs.
// - Set active, clear inactive at active edge gives true one, inverted zero.
// - Clear active, set inactive at active edge gives true zero, inverted one.
// - Both active reverses; both inactive or inactive edge holds state.
// - Command polarity picks rising edge normally, falling edge when inverted.
// - Toggle mode reverses state on every active edge, ignoring preparatory inputs.
// - Active forcing set drives state one, forcing clear zero, overriding all.
module jk_bistable_with_polarity (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       clock_enable,
  input  wire jk_bistable_pkg::polarity_t polarity,
  input  wire logic                       toggle_mode,
  input  wire jk_bistable_pkg::pins_in_t  pins_in,
  output jk_bistable_pkg::pins_out_t      pins_out
);

  // Whole registered state, its next copy and its copy after reset
  jk_bistable_pkg::state_t state;
  jk_bistable_pkg::state_t next_state;
  jk_bistable_pkg::state_t reset_state;

  // Inactive pin level of every input terminal
  logic idle_j;
  logic idle_k;
  logic idle_cmd;
  logic idle_set;
  logic idle_clear;

  // Raw pin levels at the end of the synchronisers
  logic level_j;
  logic level_k;
  logic level_cmd;
  logic level_prev;
  logic level_set;
  logic level_clear;

  // Logical values of the synchronised pins
  logic prep_j;
  logic prep_k;
  logic set_active;
  logic clear_active;
  logic cmd_level;
  logic prev_level;

  // Preparatory combination at the current sample
  logic [1:0] jk_code;
  logic       jk_hold;
  logic       jk_clear;
  logic       jk_set;
  logic       jk_reverse;

  // Command edge decode
  logic active_edge;
  logic inactive_edge;

  // Forcing decode
  logic force_one;
  logic force_zero;
  logic force_both;

  // Next stored value along the command path and after forcing
  logic load_value;
  logic after_edge;
  logic final_state;

  // Logical output values, then the pin levels they give
  logic true_value;
  logic inv_value;
  logic true_level;
  logic inv_level;

  // An idle preparatory pin carries logic zero, so its level is the polarity bit
  always_comb begin
    idle_j = polarity.j_low;
    idle_k = polarity.k_low;
  end

  // Idle command level; reset loads it so no false edge follows reset
  always_comb begin
    idle_cmd = polarity.cmd_falling;
  end

  // Idle forcing levels; reset loads them so no false force follows reset
  always_comb begin
    idle_set   = polarity.set_low;
    idle_clear = polarity.clear_low;
  end

  // Raw preparatory levels after the second flop
  always_comb begin
    level_j = state.sync2_j;
    level_k = state.sync2_k;
  end

  // Raw command level and the sample before it
  always_comb begin
    level_cmd  = state.sync2_cmd;
    level_prev = state.prev_cmd;
  end

  // Raw forcing levels after the second flop
  always_comb begin
    level_set   = state.sync2_set;
    level_clear = state.sync2_clear;
  end

  // Preparatory pins mapped to logic values
  always_comb begin
    prep_j = level_j ^ polarity.j_low;
    prep_k = level_k ^ polarity.k_low;
  end

  // Forcing pins mapped to logic values
  always_comb begin
    set_active   = level_set ^ polarity.set_low;
    clear_active = level_clear ^ polarity.clear_low;
  end

  // Command levels mapped so that logic one is always the active side
  always_comb begin
    cmd_level  = level_cmd ^ polarity.cmd_falling;
    prev_level = level_prev ^ polarity.cmd_falling;
  end

  // One flag for each preparatory combination
  always_comb begin
    jk_code    = {prep_j, prep_k};

    jk_hold    = 1'h0;
    jk_clear   = 1'h0;
    jk_set     = 1'h0;
    jk_reverse = 1'h0;

    unique case (jk_code)
      2'h0: jk_hold    = 1'h1;
      2'h1: jk_clear   = 1'h1;
      2'h2: jk_set     = 1'h1;
      2'h3: jk_reverse = 1'h1;
    endcase
  end

  // Preparatory inputs only choose what the next active edge loads
  always_comb begin
    load_value = state.stored;

    if (jk_hold) begin
      load_value = state.stored;
    end

    if (jk_set) begin
      load_value = `JK_STATE_ONE;
    end

    if (jk_clear) begin
      load_value = `JK_STATE_ZERO;
    end

    if (jk_reverse) begin
      load_value = ~state.stored;
    end

    if (toggle_mode) begin
      load_value = ~state.stored;
    end
  end

  // Active edge is a zero-to-one step of the logical command; the reverse is inactive
  always_comb begin
    active_edge   = cmd_level & ~prev_level;
    inactive_edge = ~cmd_level & prev_level;
  end

  // Forcing decode; both together is kept apart for a fixed output
  always_comb begin
    force_one  = set_active & ~clear_active;
    force_zero = clear_active & ~set_active;

    force_both = set_active & clear_active;
  end

  // Only an active command edge moves the state; an inactive edge holds it
  always_comb begin
    after_edge = state.stored;

    if (active_edge) begin
      after_edge = load_value;
    end

    if (inactive_edge) begin
      after_edge = state.stored;
    end
  end

  // A lone forcing input acts each cycle it is held and overrides an edge in the same cycle
  always_comb begin
    final_state = after_edge;

    if (force_one) begin
      final_state = `JK_STATE_ONE;
    end

    if (force_zero) begin
      final_state = `JK_STATE_ZERO;
    end

    if (force_both) begin
      final_state = after_edge;
    end
  end

  // Both forcing at once is illegal upstream; a fixed value beats an unknown
  always_comb begin
    true_value = final_state;
    inv_value  = ~final_state;

    if (force_both) begin
      true_value = `JK_BOTH_FORCED;
      inv_value  = `JK_BOTH_FORCED;
    end
  end

  // Output polarity turns logic values into pin levels
  always_comb begin
    true_level = true_value ^ polarity.true_low;
    inv_level  = inv_value ^ polarity.inv_low;
  end

  // Fill the next copy of the state; every pin passes two flops before use
  always_comb begin
    next_state                  = state;

    next_state.sync1_cmd        = pins_in.cmd;
    next_state.sync2_cmd        = state.sync1_cmd;
    next_state.prev_cmd         = state.sync2_cmd;

    next_state.sync1_j          = pins_in.j;
    next_state.sync2_j          = state.sync1_j;
    next_state.sync1_k          = pins_in.k;
    next_state.sync2_k          = state.sync1_k;

    next_state.sync1_set        = pins_in.forced_set;
    next_state.sync2_set        = state.sync1_set;
    next_state.sync1_clear      = pins_in.forced_clear;
    next_state.sync2_clear      = state.sync1_clear;

    next_state.stored           = final_state;
    next_state.both_forced      = force_both;

    next_state.out.true_out     = true_level;
    next_state.out.inverted_out = inv_level;
  end

  // Reset copy: pins look idle, and outputs already carry their polarity
  always_comb begin
    reset_state                  = '0;

    reset_state.sync1_cmd        = idle_cmd;
    reset_state.sync2_cmd        = idle_cmd;
    reset_state.prev_cmd         = idle_cmd;

    reset_state.sync1_j          = idle_j;
    reset_state.sync2_j          = idle_j;
    reset_state.sync1_k          = idle_k;
    reset_state.sync2_k          = idle_k;

    reset_state.sync1_set        = idle_set;
    reset_state.sync2_set        = idle_set;
    reset_state.sync1_clear      = idle_clear;
    reset_state.sync2_clear      = idle_clear;

    reset_state.stored           = `JK_STATE_RESET;
    reset_state.both_forced      = `JK_STATE_ZERO;

    reset_state.out.true_out     = `JK_STATE_RESET ^ polarity.true_low;
    reset_state.out.inverted_out = ~`JK_STATE_RESET ^ polarity.inv_low;
  end

  // Register the state; reset wins over the enable, a low enable freezes all
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= reset_state;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // Outputs come straight from flip-flops
  assign pins_out = state.out;

endmodule

// ---- inc/jk_bistable_defs.svh ----
`ifndef JK_BISTABLE_DEFS_SVH
`define JK_BISTABLE_DEFS_SVH

// Logic values of the stored state
`define JK_STATE_ONE    1'h1
`define JK_STATE_ZERO   1'h0
// Reset value of the stored state
`define JK_STATE_RESET  1'h0
// Value both outputs take while both forcing inputs are active
`define JK_BOTH_FORCED  1'h1

`endif

// ---- inc/jk_bistable_pkg.sv ----
package jk_bistable_pkg;

  // Polarity of one terminal: 1 means active low, or falling edge for the command input
  typedef struct packed {
    logic j_low;
    logic k_low;
    logic cmd_falling;
    logic set_low;
    logic clear_low;
    logic true_low;
    logic inv_low;
  } polarity_t;

  // Raw pin levels from upstream logic
  typedef struct packed {
    logic j;
    logic k;
    logic cmd;
    logic forced_set;
    logic forced_clear;
  } pins_in_t;

  // Pin levels driven downstream
  typedef struct packed {
    logic true_out;
    logic inverted_out;
  } pins_out_t;

  // Whole state of the bistable
  typedef struct packed {
    logic sync1_cmd;
    logic sync2_cmd;
    logic prev_cmd;
    logic sync1_j;
    logic sync2_j;
    logic sync1_k;
    logic sync2_k;
    logic sync1_set;
    logic sync2_set;
    logic sync1_clear;
    logic sync2_clear;
    logic stored;
    logic both_forced;
    pins_out_t out;
  } state_t;

endpackage

// ---- verif/upstream_logic.sv ----
`timescale 1ns/1ps
// Upstream drivers turn logical requests into pin levels of the chosen polarity
module upstream_logic (
  input  wire jk_bistable_pkg::polarity_t polarity,
  input  wire jk_bistable_pkg::pins_in_t  req,
  output jk_bistable_pkg::pins_in_t       pins_in
);
  // Both forcing requests together come only when the bench asks for them
  assign pins_in = req ^ {polarity.j_low, polarity.k_low, polarity.cmd_falling,
                          polarity.set_low, polarity.clear_low};
endmodule

// ---- verif/jk_asserts.sv ----
`timescale 1ns/1ps
module jk_asserts (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       toggle_mode,
  input wire jk_bistable_pkg::polarity_t polarity,
  input wire jk_bistable_pkg::pins_in_t  pins_in,
  input wire jk_bistable_pkg::pins_out_t pins_out
);
  logic [1:0] w;
  // Logical levels; ok waits out the synchronisers after each reset
  wire fs = pins_in.forced_set ^ polarity.set_low;
  wire fc = pins_in.forced_clear ^ polarity.clear_low;
  wire c = pins_in.cmd ^ polarity.cmd_falling;
  wire j = pins_in.j ^ polarity.j_low;
  wire k = pins_in.k ^ polarity.k_low;
  wire lt = pins_out.true_out ^ polarity.true_low;
  wire li = pins_out.inverted_out ^ polarity.inv_low;
  wire f = fs | fc;
  wire ok = &w;
  always_ff @(posedge clock) w <= srst ? 2'h0 : w + {1'h0, w != 2'h3};
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_force_set: assert property (ok && fs && !fc |-> ##3 lt)
    else $error("forced set lost");
  a_force_clear: assert property (ok && fc && !fs |-> ##3 !lt)
    else $error("forced clear lost");
  a_both_forced: assert property (ok && fs && fc |-> ##3 lt && li)
    else $error("both forced value");
  a_outs_compl: assert property (ok && !(fs && fc) |-> ##3 lt != li)
    else $error("outputs not complementary");
  a_set_edge: assert property (ok && $rose(c) && j && !k && !toggle_mode && !f |-> ##3 lt)
    else $error("set edge lost");
  a_clear_edge: assert property (ok && $rose(c) && k && !j && !toggle_mode && !f |-> ##3 !lt)
    else $error("clear edge lost");
  a_toggle_edge: assert property (ok && $rose(c) && (toggle_mode || j && k) && !f && !$past(f)
    |-> ##3 lt != $past(lt))
    else $error("no reversal");
  a_hold_state: assert property (ok && (!$rose(c) || !toggle_mode && !j && !k) && !f && !$past(f)
    |-> ##3 $stable(lt))
    else $error("state moved");
endmodule
bind jk_bistable_with_polarity jk_asserts chk (.clock, .srst, .toggle_mode, .polarity,
  .pins_in, .pins_out);

// ---- verif/jk_bistable_with_polarity_bench.sv ----
`timescale 1ns/1ps
module jk_bistable_with_polarity_bench;
  logic                       clock = 1'h0, srst = 1'h1, toggle_mode = 1'h0;
  jk_bistable_pkg::polarity_t polarity = '0;
  jk_bistable_pkg::pins_in_t  req = '0, pins_in;
  jk_bistable_pkg::pins_out_t pins_out;
  int                         error_cnt = 0, tests_run = 0, cyc = 0;
  // Row: polarity, toggle, logical j, k, start state, expected state
  logic [11:0] rows [7] = '{12'h009, 12'hFE6, 12'h00D, 12'hFE3, 12'h012, 12'h555, 12'hAAE};
  always #2 clock = ~clock;
  upstream_logic far (.polarity, .req, .pins_in);
  jk_bistable_with_polarity uut (.clock, .srst, .clock_enable(1'h1), .polarity, .toggle_mode,
    .pins_in, .pins_out);
  task automatic cmp(input logic [1:0] e);
    tests_run++;
    if (pins_out !== e) begin
      error_cnt++;
      $display("BAD pins_out exp %h got %h", e, pins_out);
    end
  endtask
  // Pin levels of a logical state, inverted output beside it
  function automatic logic [1:0] lv(input logic s);
    return {s ^ polarity.true_low, !s ^ polarity.inv_low};
  endfunction
  // Logical j, k, cmd, forced set, forced clear held for n cycles
  task automatic go(input logic [4:0] v, input int n);
    @(negedge clock);
    req = v;
    repeat (n - 1) @(negedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Polarity is static, so each row gets a short reset around its change
  task automatic repol(input logic [6:0] pv, input logic tm);
    srst = 1'h1;
    polarity = pv;
    toggle_mode = tm;
    @(negedge clock);
    srst = 1'h0;
  endtask
  // Cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    cmp(2'h1);
    foreach (rows[i]) begin
      repol(rows[i][11:5], rows[i][4]);
      go({3'h0, rows[i][1], !rows[i][1]}, 5);
      go(5'h0, 5);
      cmp(lv(rows[i][1]));
      go({rows[i][3:2], 3'h0}, 5);
      cmp(lv(rows[i][1]));
      go({rows[i][3:2], 3'h4}, 5);
      cmp(lv(rows[i][0]));
      go({rows[i][3:2], 3'h0}, 5);
      cmp(lv(rows[i][0]));
    end
    // Mid-run reset with inverted polarity: mapped reset value, no false edge after
    repol(7'h7F, 1'h0);
    cmp(lv(1'h0));
    go({2'h3, 3'h0}, 5);
    cmp(lv(1'h0));
    repol(7'h00, 1'h1);
    go(5'h3, 5);
    cmp(2'h3);
    go(5'h1, 5);
    go(5'h0, 5);
    // Back-to-back reversals at the tightest spacing
    repeat (3) begin
      go(5'h4, 1);
      go(5'h0, 1);
    end
    go(5'h0, 5);
    cmp(lv(1'h1));
    print_verdict();
  end
endmodule
